// File: core/msr_pkg.sv
// Purpose: shared constants for the module signal routing unit
// Assumes: 32-bit apb, one word per routing register
// Notes: bit positions inside the routing registers are local choices
package msr_pkg;
  // register byte addresses
  localparam logic [11:0] MSR_ADDR_A = 12'h000;
  localparam logic [11:0] MSR_ADDR_B = 12'h004;
  localparam logic [11:0] MSR_ADDR_C = 12'h008;
  localparam logic [11:0] MSR_ADDR_MODE = 12'h00C;
  // routing_reg_a fields
  localparam int MSR_A_LIN_LSB = 0;
  localparam int MSR_A_LIN_W = 3;
  localparam int MSR_A_SPI_BIT = 4;
  // routing_reg_b fields
  localparam int MSR_B_CAN_LSB = 0;
  localparam int MSR_B_CAN_W = 3;
  localparam int MSR_B_PRB_LSB = 4;
  localparam int MSR_B_PWM_BIT = 6;
  // routing_reg_c fields
  localparam int MSR_C_CH2_LSB = 0;
  localparam int MSR_C_CMP1_BIT = 2;
  localparam int MSR_C_CAP1_BIT = 3;
  localparam int MSR_C_OVR_BIT = 4;
  localparam int MSR_C_TB0_BIT = 5;
  // implemented-bit masks per variant
  localparam logic [7:0] MSR_MASK_A_BASE = 8'h10;
  localparam logic [7:0] MSR_MASK_A_LIN = 8'h07;
  localparam logic [7:0] MSR_MASK_B_BASE = 8'h50;
  localparam logic [7:0] MSR_MASK_B_EXT = 8'h27;
  localparam logic [7:0] MSR_MASK_C_QUAL = 8'h1F;
  localparam logic [7:0] MSR_MASK_C_EXT = 8'h20;
  // reset values: lin and can fields at zero route to on-chip transceivers
  localparam logic [7:0] MSR_RST_VAL = 8'h00;
  localparam int MSR_NREG = 3;
  // apb error-free data width
  localparam int MSR_DW = 32;
endpackage

// File: core/msr_reg_bank.sv
// Purpose: three routing registers, write-once outside special mode, with variant masks
// Assumes: strobes come from the apb slave on the same clock
// Notes: masks remove bits that a variant lacks
`timescale 1ns/1ps
module msr_reg_bank
  import msr_pkg::*;
#(
  parameter logic [7:0] MASK_A = 8'hFF,
  parameter logic [7:0] MASK_B = 8'hFF,
  parameter logic [7:0] MASK_C = 8'hFF
) (
  input wire logic clk,
  input wire logic reset_n,
  msr_reg_if.owner rb
);
  localparam logic [7:0] MASKS [3] = '{MASK_A, MASK_B, MASK_C};
  logic [7:0] val_q [3]; // stored routing bytes
  logic [7:0] val_d [3];
  logic [2:0] used_q; // write already taken, in either mode
  logic [2:0] used_d;

  // one slice per register
  for (genvar i = 0; i < MSR_NREG; i++) begin : g_reg
    always_comb begin
      val_d[i] = val_q[i];
      used_d[i] = used_q[i];
      // normal mode: first write only; special: always
      if (rb.wrHit[i] && (rb.specialMode || !used_q[i])) begin
        val_d[i] = rb.wrData & MASKS[i];
        used_d[i] = 1'b1;
      end
    end
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        val_q[i] <= MSR_RST_VAL;
        used_q[i] <= 1'b0;
      end else begin
        val_q[i] <= val_d[i];
        used_q[i] <= used_d[i];
      end
    end
    assign rb.regVal[i] = val_q[i];

    // a locked register keeps its value outside special mode
    lock_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      used_q[i] && !rb.specialMode |=> $stable(val_q[i]))
      else $error("locked routing register changed");
    mask_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      (val_q[i] & ~MASKS[i]) == 8'h00)
      else $error("unimplemented routing bit set");
  end
endmodule

// File: core/msr_reg_if.sv
// Purpose: carries register contents and write strobes between routing modules
// Assumes: single clock
// Notes: one entry per routing register
`timescale 1ns/1ps
interface msr_reg_if;
  logic [7:0] regVal [3]; // current register contents
  logic [2:0] wrHit; // one-cycle write strobe per register
  logic [7:0] wrData; // low byte of write data
  logic specialMode; // unlimited writes when high
  modport owner (output regVal, input wrHit, input wrData, input specialMode);
  modport user (input regVal, output wrHit, output wrData, output specialMode);
endinterface

// File: core/msr_routing.sv
// Purpose: module signal routing unit top with apb register access
// Assumes: apb slave, zero wait states, 250 MHz clock
// Notes: pin-level muxing outputs are registered one cycle
`timescale 1ns/1ps
module msr_routing
  import msr_pkg::*;
#(
  parameter bit EXT_VARIANT = 1'b1, // extended can variant
  parameter bit LIN_VARIANT = 1'b0, // lin variant
  parameter bit CAP_VARIANT = 1'b1 // timer capture options present
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  input wire logic serialTx,
  output logic linTransceiverTx,
  output logic serialPinTx,
  input wire logic linTransceiverRx,
  input wire logic serialPinRx,
  output logic serialRx,
  // spi clock and select pin steering
  output logic spiClkOnPs1,
  output logic spiClkOnPs4,
  output logic spiSelOnPs0,
  output logic spiSelOnPs5,
  // can
  input wire logic canTxLine,
  output logic canTransceiverTx,
  output logic canPinTx,
  input wire logic canTransceiverRx,
  input wire logic canPinRx,
  output logic canRxLine,
  // pwm
  input wire logic [5:0] pwmOut,
  output logic [5:0] gateDriverPwm,
  output logic pinPt0,
  output logic pinPt1,
  output logic pinPt2,
  output logic pinPt3,
  output logic pinPp0,
  output logic pinPp1,
  output logic pinPp2,
  output logic [1:0] pwmProbeEn,
  // timer capture sources
  input wire logic capPin1,
  input wire logic hallEvent,
  input wire logic cmp1Loop,
  input wire logic capPin2,
  input wire logic highVoltageInput,
  input wire logic gateDriverDelay,
  input wire logic timerBPin0,
  output logic timerCaptureIn01,
  output logic timerCaptureIn02,
  output logic timerBCapture0
);
  // variant masks, unimplemented bits vanish
  localparam logic [7:0] MASK_A = MSR_MASK_A_BASE | (LIN_VARIANT ? MSR_MASK_A_LIN : 8'h00);
  localparam logic [7:0] MASK_B = EXT_VARIANT ? (MSR_MASK_B_BASE | MSR_MASK_B_EXT) : MSR_MASK_B_BASE;
  localparam logic [7:0] MASK_C = (CAP_VARIANT ? MSR_MASK_C_QUAL : 8'h00) | (EXT_VARIANT ? MSR_MASK_C_EXT : 8'h00);

  msr_reg_if rbus ();
  logic mode_q; // special mode bit
  logic mode_d;
  logic [31:0] rdata_q; // read data
  logic [31:0] rdata_d;
  logic ready_q; // access-phase answer
  logic ready_d;
  logic err_q;
  logic err_d;
  logic setup; // setup cycle seen
  logic [7:0] ra; // shorthand register bytes
  logic [7:0] rbv;
  logic [7:0] rc;

  msr_reg_bank #(
    .MASK_A(MASK_A),
    .MASK_B(MASK_B),
    .MASK_C(MASK_C)
  ) u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .rb(rbus.owner)
  );

  // shorthand views of the stored routing bytes
  assign ra = rbus.regVal[0];
  assign rbv = rbus.regVal[1];
  assign rc = rbus.regVal[2];
  // setup cycle of an apb transfer, the only cycle that decodes reads
  assign setup = psel && !penable;

  // write strobes fire in the access phase only
  always_comb begin
    rbus.wrHit = 3'b000;
    if (psel && penable && pwrite) begin
      rbus.wrHit[0] = (paddr == MSR_ADDR_A);
      rbus.wrHit[1] = (paddr == MSR_ADDR_B);
      rbus.wrHit[2] = (paddr == MSR_ADDR_C);
    end
  end
  assign rbus.wrData = pwdata[7:0];
  assign rbus.specialMode = mode_q;

  // apb answer: zero wait states, read data captured at setup
  always_comb begin
    mode_d = mode_q;
    rdata_d = rdata_q;
    ready_d = 1'b0;
    err_d = 1'b0;
    if (setup) begin
      ready_d = 1'b1;
      rdata_d = 32'h0000_0000;
      unique case (paddr)
        MSR_ADDR_A: rdata_d[7:0] = ra;
        MSR_ADDR_B: rdata_d[7:0] = rbv;
        MSR_ADDR_C: rdata_d[7:0] = rc;
        MSR_ADDR_MODE: rdata_d[0] = mode_q;
        default: err_d = 1'b1; // unmapped
      endcase
    end
    if (psel && penable && pwrite && paddr == MSR_ADDR_MODE) begin
      mode_d = pwdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;

  // routing decode
  logic linSel; // serial goes to pins when set
  logic spiAlt;
  logic canPin;
  logic pwmPin;
  logic cap1Sel;
  logic [7:0] pinNext;
  logic [5:0] gdNext;
  logic cin01;
  logic cin02;
  logic tb0;
  // field value zero keeps transceivers connected, the reset default
  assign linSel = ra[MSR_A_LIN_LSB +: MSR_A_LIN_W] != 3'b000;
  assign spiAlt = ra[MSR_A_SPI_BIT];
  assign canPin = rbv[MSR_B_CAN_LSB +: MSR_B_CAN_W] != 3'b000;
  assign pwmPin = rbv[MSR_B_PWM_BIT];

  // pwm pin map; channels 1,3,4 identical on all variants
  always_comb begin
    pinNext = 8'h00;
    gdNext = pwmPin ? 6'h00 : pwmOut;
    if (pwmPin) begin
      pinNext[0] = pwmOut[3]; // pt0
      pinNext[1] = pwmOut[4]; // pt1
      pinNext[5] = pwmOut[1]; // pp1
      if (EXT_VARIANT) begin
        pinNext[2] = pwmOut[0];
        pinNext[3] = pwmOut[2];
        pinNext[4] = pwmOut[5];
      end else begin
        // base variant pin map
        pinNext[4] = pwmOut[0];
        pinNext[6] = pwmOut[2];
        pinNext[2] = pwmOut[5];
      end
    end
  end

  // capture routing, override wins over both selections
  always_comb begin
    cap1Sel = rc[MSR_C_CAP1_BIT];
    cin01 = capPin1;
    if (rc[MSR_C_OVR_BIT]) begin
      cin01 = hallEvent;
    end else if (cap1Sel) begin
      cin01 = hallEvent;
    end else if (rc[MSR_C_CMP1_BIT]) begin
      cin01 = cmp1Loop;
    end
    // high-voltage input only exists on the extended variant
    cin02 = (rc[MSR_C_CH2_LSB +: 2] == 2'b01 && EXT_VARIANT) ? highVoltageInput : capPin2;
    tb0 = rc[MSR_C_TB0_BIT] ? gateDriverDelay : timerBPin0;
  end

  // all outputs registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // tx lines idle high so the links stay recessive in reset
      linTransceiverTx <= 1'b1;
      serialPinTx <= 1'b1;
      serialRx <= 1'b1;
      spiClkOnPs1 <= 1'b0;
      spiClkOnPs4 <= 1'b0;
      spiSelOnPs0 <= 1'b0;
      spiSelOnPs5 <= 1'b0;
      canTransceiverTx <= 1'b1;
      canPinTx <= 1'b1;
      canRxLine <= 1'b1;
      gateDriverPwm <= 6'h00;
      {pinPp2, pinPp1, pinPp0, pinPt3, pinPt2, pinPt1, pinPt0} <= 7'h00;
      pwmProbeEn <= 2'b00;
      timerCaptureIn01 <= 1'b0;
      timerCaptureIn02 <= 1'b0;
      timerBCapture0 <= 1'b0;
    end else begin
      // serial link: field zero keeps the on-chip transceiver
      linTransceiverTx <= linSel ? 1'b1 : serialTx;
      serialPinTx <= linSel ? serialTx : 1'b1;
      serialRx <= linSel ? serialPinRx : linTransceiverRx;
      // spi pins differ per variant, the select bit picks the alternative
      spiClkOnPs1 <= EXT_VARIANT && spiAlt;
      spiClkOnPs4 <= !EXT_VARIANT && spiAlt;
      spiSelOnPs0 <= EXT_VARIANT && spiAlt;
      spiSelOnPs5 <= !EXT_VARIANT && spiAlt;
      // can pair, on-chip transceiver by default
      canTransceiverTx <= canPin ? 1'b1 : canTxLine;
      canPinTx <= canPin ? canTxLine : 1'b1;
      canRxLine <= canPin ? canPinRx : canTransceiverRx;
      // pwm to gate driver or pins, plus probe enables
      gateDriverPwm <= gdNext;
      {pinPp2, pinPp1, pinPp0, pinPt3, pinPt2, pinPt1, pinPt0} <= pinNext[6:0];
      pwmProbeEn <= rbv[MSR_B_PRB_LSB +: 2];
      // timer capture inputs
      timerCaptureIn01 <= cin01;
      timerCaptureIn02 <= cin02;
      timerBCapture0 <= tb0;
    end
  end

  // assertions
  sequence ovrSet;
    rc[MSR_C_OVR_BIT] && hallEvent;
  endsequence
  ovr_wins_a: assert property (@(posedge clk) disable iff (!reset_n)
    ovrSet |=> timerCaptureIn01)
    else $error("override did not route hall event");
  lin_default_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ra[2:0] == 3'b000) |=> serialRx == $past(linTransceiverRx))
    else $error("serial rx not from lin transceiver");
  can_default_a: assert property (@(posedge clk) disable iff (!reset_n)
    !canPin |=> canRxLine == $past(canTransceiverRx))
    else $error("can rx not from transceiver");
  // upper probe bit only reachable where the variant implements it
  probe_hi_a: assert property (@(posedge clk) disable iff (!reset_n)
    pwmProbeEn[1] |-> EXT_VARIANT && $past(rbv[MSR_B_PRB_LSB + 1]))
    else $error("probe upper bit set without extended variant");
  pwm_gd_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pwmPin |=> gateDriverPwm == $past(pwmOut))
    else $error("pwm not to gate driver");
  // pins stay low while the gate driver owns the pwm signals
  pwm_pin_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pwmPin |=> {pinPp2, pinPp1, pinPp0, pinPt3, pinPt2, pinPt1, pinPt0} == 7'h00)
    else $error("pwm pins driven while routed to gate driver");
  tdel_meas_a: assert property (@(posedge clk) disable iff (!reset_n)
    rc[MSR_C_TB0_BIT] |=> timerBCapture0 == $past(gateDriverDelay))
    else $error("delay signal not routed");
  // extended variant routes the high-voltage input to capture input 0_2 when the field holds 01
  hvi_route_a: assert property (@(posedge clk) disable iff (!reset_n)
    EXT_VARIANT && (rc[1:0] == 2'b01) |=> timerCaptureIn02 == $past(highVoltageInput))
    else $error("high voltage input not routed");
  spi_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    spiClkOnPs1 |-> !spiClkOnPs4 && spiSelOnPs0)
    else $error("spi pin steering inconsistent");
  // compare loopback reaches capture 1 only when no capture option is set
  sequence cmpOnly;
    rc[MSR_C_CMP1_BIT] && !rc[MSR_C_CAP1_BIT] && !rc[MSR_C_OVR_BIT];
  endsequence
  cmp_loop_a: assert property (@(posedge clk) disable iff (!reset_n)
    cmpOnly |=> timerCaptureIn01 == $past(cmp1Loop))
    else $error("compare loopback not routed");
  // apb answer is a single-cycle pulse, never stretched
  ready_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
endmodule

// File: test/tb.sv
// Purpose: self-checking bench for the module signal routing unit
// Assumes: all variant options on, apb answer comes within a few cycles
// Notes: routed outputs lag inputs by one clock, so checks wait three edges
`timescale 1ns/1ps
module tb;
  import msr_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic serialTx, linTransceiverTx, serialPinTx, linTransceiverRx, serialPinRx, serialRx;
  logic spiClkOnPs1, spiClkOnPs4, spiSelOnPs0, spiSelOnPs5;
  logic canTxLine, canTransceiverTx, canPinTx, canTransceiverRx, canPinRx, canRxLine;
  logic [5:0] pwmOut, gateDriverPwm;
  logic pinPt0, pinPt1, pinPt2, pinPt3, pinPp0, pinPp1, pinPp2;
  logic [1:0] pwmProbeEn;
  logic capPin1, hallEvent, cmp1Loop, capPin2, highVoltageInput, gateDriverDelay, timerBPin0;
  logic timerCaptureIn01, timerCaptureIn02, timerBCapture0;
  int miscompares = 0; // mismatches so far
  int nCompared = 0; // comparisons so far
  // every option present, so each field can be exercised
  msr_routing #(.EXT_VARIANT(1'b1), .LIN_VARIANT(1'b1), .CAP_VARIANT(1'b1)) msr_routing_i (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serialTx, .linTransceiverTx, .serialPinTx, .linTransceiverRx, .serialPinRx, .serialRx,
    .spiClkOnPs1, .spiClkOnPs4, .spiSelOnPs0, .spiSelOnPs5,
    .canTxLine, .canTransceiverTx, .canPinTx, .canTransceiverRx, .canPinRx, .canRxLine,
    .pwmOut, .gateDriverPwm, .pinPt0, .pinPt1, .pinPt2, .pinPt3, .pinPp0, .pinPp1, .pinPp2,
    .pwmProbeEn, .capPin1, .hallEvent, .cmp1Loop, .capPin2, .highVoltageInput,
    .gateDriverDelay, .timerBPin0, .timerCaptureIn01, .timerCaptureIn02, .timerBCapture0);
  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // single compare point, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // apb transfer; called just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic err);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // bounded wait, sampled at the edge itself
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("ERROR %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic e;
    apb(1'b1, a, {24'h000000, d}, e);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    logic e;
    apb(1'b0, a, 32'h00000000, e);
    chk(rd, {24'h000000, exp});
    chk({31'h00000000, e}, 32'h00000000);
  endtask
  // let a routing change reach the registered outputs
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  // defaults route serial, can and pwm to on-chip partners
  task automatic t_reset();
    rdchk(MSR_ADDR_A, 8'h00);
    rdchk(MSR_ADDR_B, 8'h00);
    rdchk(MSR_ADDR_C, 8'h00);
    chk(linTransceiverTx, 1'b0);
    chk(serialRx, 1'b0);
    chk(canTransceiverTx, 1'b0);
    chk(canRxLine, 1'b0);
    chk(gateDriverPwm, 6'h25);
    chk(timerCaptureIn01, 1'b0);
    $display("test reset done");
  endtask
  // normal mode: first write sticks, second is dropped
  task automatic t_lock();
    wr(MSR_ADDR_A, 8'hFF);
    rdchk(MSR_ADDR_A, 8'h17);
    wr(MSR_ADDR_A, 8'h00);
    rdchk(MSR_ADDR_A, 8'h17);
    settle();
    chk(serialPinTx, 1'b0);
    chk(linTransceiverTx, 1'b1);
    chk(serialRx, 1'b1);
    chk({spiClkOnPs1, spiClkOnPs4, spiSelOnPs0, spiSelOnPs5}, 4'hA);
    $display("test lock done");
  endtask
  // special mode allows rewriting; pwm and can steering
  task automatic t_special();
    wr(MSR_ADDR_MODE, 8'h01);
    rdchk(MSR_ADDR_MODE, 8'h01);
    wr(MSR_ADDR_B, 8'hFF);
    rdchk(MSR_ADDR_B, 8'h77);
    settle();
    chk(canPinTx, 1'b0);
    chk(canRxLine, 1'b1);
    chk(canTransceiverTx, 1'b1);
    chk(pwmProbeEn, 2'b11);
    chk({pinPt0, pinPt1, pinPt2, pinPt3, pinPp0, pinPp1, pinPp2}, 7'h1C);
    chk(gateDriverPwm, 6'h00);
    wr(MSR_ADDR_B, 8'h10);
    rdchk(MSR_ADDR_B, 8'h10);
    settle();
    chk(pwmProbeEn, 2'b01);
    chk(gateDriverPwm, 6'h25);
    $display("test special done");
  endtask
  // capture steering table: value written, then expected captures
  task automatic t_capture();
    logic [7:0] v [4] = '{8'h08, 8'h04, 8'h14, 8'h21};
    logic [2:0] e [4] = '{3'b100, 3'b100, 3'b100, 3'b011};
    // compare loopback level per step, so each source differs from the one it must beat
    logic c [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    wr(MSR_ADDR_C, 8'hFF);
    rdchk(MSR_ADDR_C, 8'h3F);
    for (int i = 0; i < 4; i++) begin
      cmp1Loop <= c[i];
      wr(MSR_ADDR_C, v[i]);
      settle();
      chk({timerCaptureIn01, timerCaptureIn02, timerBCapture0}, e[i]);
    end
    $display("test capture done");
  endtask
  // unmapped address answers with an error and zero data
  task automatic t_unmapped();
    logic e;
    apb(1'b0, 12'h010, 32'h00000000, e);
    chk(rd, 32'h00000000);
    chk({31'h00000000, e}, 32'h00000001);
    $display("test unmapped done");
  endtask
  // a fresh reset clears locks and special mode
  task automatic t_rereset();
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(MSR_ADDR_MODE, 8'h00);
    rdchk(MSR_ADDR_C, 8'h00);
    wr(MSR_ADDR_C, 8'h08);
    wr(MSR_ADDR_C, 8'h21);
    rdchk(MSR_ADDR_C, 8'h08);
    settle();
    chk({timerCaptureIn01, timerCaptureIn02, timerBCapture0}, 3'b100);
    $display("test rereset done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 112 cycles the tests need
  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end
  // main sequence
  initial begin
    reset_n <= 1'b0;
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {serialTx, linTransceiverRx, serialPinRx} <= 3'b001;
    {canTxLine, canTransceiverRx, canPinRx} <= 3'b001;
    pwmOut <= 6'h25;
    {capPin1, hallEvent, cmp1Loop, capPin2, highVoltageInput} <= 5'b01001;
    {gateDriverDelay, timerBPin0} <= 2'b10;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    settle();
    t_reset();
    t_lock();
    t_special();
    t_capture();
    t_unmapped();
    t_rereset();
    report_and_stop();
  end
endmodule
